// File: hw/periodic_timer_pulse_capture.sv
// Periodic timer core: single-shot pulse output and capture input modes.
//
// Function
// R1: Firmware selects pulse mode with mode 10 and io-control 11, kept.
// R2: In pulse mode a run bit rise starts counting and the leading edge.
// R3: In pulse mode an external clock pin edge sets the run bit.
// R4: Clearing the run bit, by firmware or compare A, ends the pulse.
// R5: Compare A match clears run, ends pulse and raises the interrupt.
// R6: Pulse mode clears the counter only on run rise; period unused.
// R7: Firmware keeps the run bit high while the pulse is active.
// R8: Mode 01 selects capture mode, edges store the counter.
// R9: Capture source is the capture pin or external clock pin.
// R10: io-control picks rise, fall, both; 11 captures nothing, counter runs.
// R11: Capture mode counter starts on run rise, free-runs until run falls.
// R12: Each selected edge latches the counter into A or B, interrupt.
// R13: Edge select and clear condition jointly choose the capture target.
// R14: Period match clears the counter with interrupt; zero means full range.
// R15: Clear condition adds rise, fall or both edge counter clears.
// R16: Clear condition 00 captures into A only; overflow flag meaningless.
// R17: Capture pulses under two timer clocks may be missed.
// R18: Capture mode ignores clear-select, initial state, polarity; no output.
// R19: Counter and compare registers are ten bits, low and high bytes.
// R20: Active pulse holds level from initial state and polarity.
`include "periodic_timer_map.svh"
`timescale 1ns/10ps
`default_nettype none

module periodic_timer_pulse_capture (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire periodic_timer_pkg::bus_req_t bus_in,
  output logic [7:0]                      rdata_out,
  input  wire logic                       timer_ext_clock_pin_in,
  input  wire logic [3:0]                 timer_capture_pin_in,
  output logic                            timer_output_out,
  output logic                            timer_int_out,
  output logic                            timer_run_out
);
  import periodic_timer_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [7:0] ctrl1_reg,  ctrl1_next;
  logic [1:0] tclr_reg,   tclr_next;
  logic [1:0] pinsrc_reg, pinsrc_next;
  logic       run_reg,    run_next;
  logic       run_prev_reg, run_prev_next;
  logic [9:0] count_reg,  count_next;
  logic [9:0] compare_a_value_reg,   compare_a_value_next;
  logic [9:0] compare_b_value_reg,   compare_b_value_next;
  logic [9:0] period_compare_value_reg,   period_compare_value_next;
  logic [3:0] status_reg, status_next;
  logic [7:0] rdata_reg,  rdata_next;
  logic       out_reg,    out_next;
  logic       int_reg,    int_next;
  ctrl_t      ctrl;
  logic [4:0] pin_level, pin_rise, pin_fall;
  logic       pulse_mode, cap_mode, run_rise;
  logic       match_a, match_p, cap_rise, cap_fall;
  logic       cap_fire, cap_to_b, edge_clear, active_level;
  logic [9:0] period_top;
  edge_sel_t  edge_sel;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; bit 4 is the external clock pin.

  pin_edge_sync #(
    .WIDTH     (5)
  ) u_sync ( // R17
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    ({timer_ext_clock_pin_in, timer_capture_pin_in}),
    .level_out (pin_level),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  //////////////////////////////////////////////////////////////////////////
  // Control decode and event detection.

  // Unpack the control fields into one carrier.
  always_comb begin
    ctrl.mode        = mode_t'(ctrl1_reg[`PT_MODE_MSB:`PT_MODE_LSB]);
    ctrl.io_ctrl     = ctrl1_reg[`PT_IO_MSB:`PT_IO_LSB];
    ctrl.init_state  = ctrl1_reg[`PT_INIT_BIT];
    ctrl.polarity    = ctrl1_reg[`PT_POL_BIT];
    ctrl.cap_src_sel = ctrl1_reg[`PT_CAPSRC_BIT];
    ctrl.clear_cond  = tclr_reg;
    ctrl.pin_src     = pinsrc_reg;
  end

  // Pulse mode needs io-control at 11 as well as mode 10.
  assign pulse_mode = (ctrl.mode == MODE_PULSE) && (ctrl.io_ctrl == 2'b11); // R1
  assign cap_mode   = (ctrl.mode == MODE_CAPTURE); // R8
  assign run_rise   = run_reg && !run_prev_reg;
  assign edge_sel   = edge_sel_t'(ctrl.io_ctrl);
  assign active_level = ctrl.init_state ^ ctrl.polarity; // R20

  // A period of zero runs the counter over its full range.
  assign period_top = (period_compare_value_reg == `PT_RST_COUNT) ? `PT_COUNT_MAX
                                                  : period_compare_value_reg; // R14

  // Compare A only counts once the start cycle has passed.
  assign match_a = pulse_mode && run_reg && !run_rise &&
                   (count_reg == compare_a_value_reg); // R5
  assign match_p = cap_mode && run_reg && !run_rise &&
                   (count_reg == period_top); // R14

  // Pick the capture source after synchronising every candidate pin.
  always_comb begin
    if (ctrl.cap_src_sel) begin // R9
      cap_rise = pin_rise[4];
      cap_fall = pin_fall[4];
    end else begin
      cap_rise = pin_rise[ctrl.pin_src];
      cap_fall = pin_fall[ctrl.pin_src];
    end
  end

  // Selected capture edge and its destination register.
  always_comb begin
    case (edge_sel)
      EDGE_RISE: cap_fire = cap_rise;
      EDGE_FALL: cap_fire = cap_fall;
      EDGE_BOTH: cap_fire = cap_rise || cap_fall;
      EDGE_NONE: cap_fire = 1'b0; // R10
      default:   cap_fire = 1'b0;
    endcase
    cap_fire = cap_fire && cap_mode && run_reg; // R12
    // With extra clears enabled, falling edges land in B.
    cap_to_b = (ctrl.clear_cond != 2'b00) && cap_fall && !cap_rise; // R13 R16
    case (ctrl.clear_cond)
      2'b01:   edge_clear = cap_rise; // R15
      2'b10:   edge_clear = cap_fall; // R15
      2'b11:   edge_clear = cap_rise || cap_fall; // R15
      default: edge_clear = 1'b0;
    endcase
    edge_clear = edge_clear && cap_mode && run_reg;
  end

  //////////////////////////////////////////////////////////////////////////
  // Run bit, counter and output.

  // Run bit: firmware write, then hardware clear, then hardware set.
  always_comb begin
    run_next = run_reg;
    if (bus_in.wr && bus_in.addr == `PT_ADDR_CTRL0) begin
      run_next = bus_in.wdata[`PT_RUN_BIT];
    end
    if (match_a) begin
      run_next = 1'b0; // R4 R5
    end
    if (pulse_mode && pin_rise[4]) begin
      run_next = 1'b1; // R3
    end
    run_prev_next = run_reg;
  end

  // Counter: zero on run rise, wraps at the period in capture mode.
  always_comb begin
    count_next = count_reg;
    if (run_rise && (pulse_mode || cap_mode)) begin
      count_next = `PT_RST_COUNT; // R2 R6 R11
    end else if (run_reg && (match_p || edge_clear)) begin
      count_next = `PT_RST_COUNT; // R14 R15
    end else if (run_reg && (pulse_mode || cap_mode)) begin
      count_next = 10'(count_reg + 10'h001); // R11
    end
  end

  // Pulse mode follows run; capture mode freezes the pin against bit changes.
  always_comb begin
    out_next = !active_level; // R4
    if (pulse_mode && run_next) begin
      out_next = active_level; // R2 R20
    end else if (cap_mode) begin
      out_next = out_reg; // R18
    end
    int_next = match_a || match_p || cap_fire; // R5 R12 R14
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_reg      <= 1'b0;
      run_prev_reg <= 1'b0;
      count_reg    <= `PT_RST_COUNT;
      out_reg      <= 1'b1;
      int_reg      <= 1'b0;
    end else begin
      run_reg      <= run_next;
      run_prev_reg <= run_prev_next;
      count_reg    <= count_next;
      out_reg      <= out_next;
      int_reg      <= int_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file.

  // Writes and captures; a capture wins over a firmware write.
  always_comb begin
    ctrl1_next  = ctrl1_reg;
    tclr_next   = tclr_reg;
    pinsrc_next = pinsrc_reg;
    compare_a_value_next   = compare_a_value_reg;
    compare_b_value_next   = compare_b_value_reg;
    period_compare_value_next   = period_compare_value_reg;
    status_next = status_reg;
    if (bus_in.wr) begin
      case (bus_in.addr)
        `PT_ADDR_CTRL1:   ctrl1_next  = bus_in.wdata;
        `PT_ADDR_CTRL2:   tclr_next   = bus_in.wdata[`PT_TCLR_MSB:`PT_TCLR_LSB];
        `PT_ADDR_INSRC:   pinsrc_next = bus_in.wdata[`PT_PINSRC_MSB:`PT_PINSRC_LSB];
        `PT_ADDR_STATUS:  status_next = status_reg & ~bus_in.wdata[3:0];
        `PT_ADDR_COMPARE_A_VALUE_LO: compare_a_value_next[7:0] = bus_in.wdata; // R19
        `PT_ADDR_COMPARE_A_VALUE_HI: compare_a_value_next[9:8] = bus_in.wdata[1:0]; // R19
        `PT_ADDR_COMPARE_B_VALUE_LO: compare_b_value_next[7:0] = bus_in.wdata; // R19
        `PT_ADDR_COMPARE_B_VALUE_HI: compare_b_value_next[9:8] = bus_in.wdata[1:0]; // R19
        `PT_ADDR_PERIOD_COMPARE_VALUE_LO: period_compare_value_next[7:0] = bus_in.wdata; // R19
        `PT_ADDR_PERIOD_COMPARE_VALUE_HI: period_compare_value_next[9:8] = bus_in.wdata[1:0]; // R19
        default: ;
      endcase
    end
    if (cap_fire && cap_to_b) begin
      compare_b_value_next = count_reg; // R12 R13
    end else if (cap_fire) begin
      compare_a_value_next = count_reg; // R12 R16
    end
    // Hardware sets beat a same-cycle clear.
    if (match_a) status_next[`PT_ST_MATCH_A] = 1'b1;
    if (match_p) status_next[`PT_ST_MATCH_P] = 1'b1;
    if (cap_fire) status_next[`PT_ST_CAPTURE] = 1'b1;
    if (match_p && ctrl.clear_cond != 2'b00) begin
      status_next[`PT_ST_OVERFLOW] = 1'b1; // R16
    end
  end

  // Read data stand for one cycle after the read strobe.
  always_comb begin
    rdata_next = `PT_RST_BYTE;
    if (bus_in.rd) begin
      case (bus_in.addr)
        `PT_ADDR_CTRL0:   rdata_next = {7'h00, run_reg};
        `PT_ADDR_CTRL1:   rdata_next = ctrl1_reg;
        `PT_ADDR_CTRL2:   rdata_next = {6'h00, tclr_reg};
        `PT_ADDR_INSRC:   rdata_next = {pinsrc_reg, 6'h00};
        `PT_ADDR_STATUS:  rdata_next = {4'h0, status_reg};
        `PT_ADDR_CNT_LO:  rdata_next = count_reg[7:0];
        `PT_ADDR_CNT_HI:  rdata_next = {6'h00, count_reg[9:8]};
        `PT_ADDR_COMPARE_A_VALUE_LO: rdata_next = compare_a_value_reg[7:0];
        `PT_ADDR_COMPARE_A_VALUE_HI: rdata_next = {6'h00, compare_a_value_reg[9:8]};
        `PT_ADDR_COMPARE_B_VALUE_LO: rdata_next = compare_b_value_reg[7:0];
        `PT_ADDR_COMPARE_B_VALUE_HI: rdata_next = {6'h00, compare_b_value_reg[9:8]};
        `PT_ADDR_PERIOD_COMPARE_VALUE_LO: rdata_next = period_compare_value_reg[7:0];
        `PT_ADDR_PERIOD_COMPARE_VALUE_HI: rdata_next = {6'h00, period_compare_value_reg[9:8]};
        default:          rdata_next = `PT_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl1_reg  <= `PT_RST_BYTE;
      tclr_reg   <= 2'b00;
      pinsrc_reg <= 2'b00;
      compare_a_value_reg   <= `PT_RST_COUNT;
      compare_b_value_reg   <= `PT_RST_COUNT;
      period_compare_value_reg   <= `PT_RST_COUNT;
      status_reg <= 4'h0;
      rdata_reg  <= `PT_RST_BYTE;
    end else begin
      ctrl1_reg  <= ctrl1_next;
      tclr_reg   <= tclr_next;
      pinsrc_reg <= pinsrc_next;
      compare_a_value_reg   <= compare_a_value_next;
      compare_b_value_reg   <= compare_b_value_next;
      period_compare_value_reg   <= period_compare_value_next;
      status_reg <= status_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign rdata_out        = rdata_reg;
  assign timer_output_out = out_reg;
  assign timer_int_out    = int_reg;
  assign timer_run_out    = run_reg;

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence seq_pulse_start;
    pulse_mode && run_rise;
  endsequence
  sequence seq_pulse_end;
    match_a ##1 (!run_reg && timer_output_out == !active_level);
  endsequence

  a_run_rise_zero: assert property ( // R6
    (run_rise && (pulse_mode || cap_mode)) |=> (count_reg == 10'h000))
    else $error("Counter not zeroed after run rise.");

  a_pulse_leading: assert property ( // R2
    seq_pulse_start |-> (timer_output_out == active_level) ##1
    (count_reg == 10'h000))
    else $error("Pulse leading edge missing.");

  a_ext_trigger_run: assert property ( // R3
    (pulse_mode && pin_rise[4]) |=> run_reg)
    else $error("External edge did not set run.");

  a_match_a_stop: assert property ( // R5
    match_a |=> (!run_reg && timer_int_out))
    else $error("Compare A did not stop the pulse.");

  a_pulse_trailing: assert property ( // R4
    match_a |-> seq_pulse_end)
    else $error("Pulse trailing edge missing.");

  a_period_wrap: assert property ( // R14
    (match_p && !$past(run_rise)) |=> (count_reg == 10'h000 && timer_int_out))
    else $error("Period match did not clear counter.");

  a_capture_latch: assert property ( // R12
    (cap_fire && !cap_to_b) |=> (compare_a_value_reg == $past(count_reg)))
    else $error("Capture did not latch into A.");

  a_capture_none: assert property ( // R10
    (cap_mode && edge_sel == EDGE_NONE && !match_p) |=> !timer_int_out)
    else $error("Capture with edge select 11.");

  a_clear_00_a_only: assert property ( // R16
    (cap_fire && !bus_in.wr && tclr_reg == 2'b00) |=> $stable(compare_b_value_reg))
    else $error("Capture went to B with clear condition 00.");

  a_capture_no_output: assert property ( // R18
    (cap_mode && $past(cap_mode)) |-> $stable(timer_output_out))
    else $error("Output moved in capture mode.");

endmodule : periodic_timer_pulse_capture

`default_nettype wire

// File: hw/periodic_timer_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef PERIODIC_TIMER_MAP_SVH
`define PERIODIC_TIMER_MAP_SVH

// Register indices on the plain register port.
`define PT_ADDR_CTRL0      4'h0
`define PT_ADDR_CTRL1      4'h1
`define PT_ADDR_CTRL2      4'h2
`define PT_ADDR_INSRC      4'h3
`define PT_ADDR_STATUS     4'h4
`define PT_ADDR_CNT_LO     4'h5
`define PT_ADDR_CNT_HI     4'h6
`define PT_ADDR_COMPARE_A_VALUE_LO    4'h7
`define PT_ADDR_COMPARE_A_VALUE_HI    4'h8
`define PT_ADDR_COMPARE_B_VALUE_LO    4'h9
`define PT_ADDR_COMPARE_B_VALUE_HI    4'hA
`define PT_ADDR_PERIOD_COMPARE_VALUE_LO    4'hB
`define PT_ADDR_PERIOD_COMPARE_VALUE_HI    4'hC

// Field positions.
`define PT_RUN_BIT         0
`define PT_MODE_MSB        7
`define PT_MODE_LSB        6
`define PT_IO_MSB          5
`define PT_IO_LSB          4
`define PT_INIT_BIT        3
`define PT_POL_BIT         2
`define PT_CAPSRC_BIT      1
`define PT_CCLR_BIT        0
`define PT_TCLR_MSB        1
`define PT_TCLR_LSB        0
`define PT_PINSRC_MSB      7
`define PT_PINSRC_LSB      6
`define PT_ST_MATCH_A      0
`define PT_ST_MATCH_P      1
`define PT_ST_CAPTURE      2
`define PT_ST_OVERFLOW     3

// Reset values and the counter maximum.
`define PT_RST_BYTE        8'h00
`define PT_RST_COUNT       10'h000
`define PT_COUNT_MAX       10'h3FF

// Timer clock period and shortest capture pulse, in timer clocks.
`define PT_CLK_PERIOD_NS   40
`define PT_MIN_CAP_CYCLES  2

`endif

// File: hw/periodic_timer_pkg.sv
// Types shared by the periodic timer pulse and capture block.
package periodic_timer_pkg;

  // Operating modes of the mode-select field.
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PULSE   = 2'b10,
    MODE_TIMER   = 2'b11
  } mode_t;

  // Capture edge choice held in the io-control field.
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_NONE = 2'b11
  } edge_sel_t;

  // One register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  // Control fields gathered from the control registers.
  typedef struct packed {
    mode_t      mode;
    logic [1:0] io_ctrl;
    logic       init_state;
    logic       polarity;
    logic       cap_src_sel;
    logic [1:0] clear_cond;
    logic [1:0] pin_src;
  } ctrl_t;

endpackage : periodic_timer_pkg

// File: hw/pin_edge_sync.sv
// Two-stage pin synchroniser with rising and falling edge pulses.
`timescale 1ns/10ps
`default_nettype none

module pin_edge_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;
  logic [WIDTH-1:0] prev_next;

  // Next values: the first stage feeds only the second.
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // Synchroniser and history flops.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // Edges compare the settled stage with its history.
  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~prev_reg;
  assign fall_out  = ~sync_reg & prev_reg;

endmodule : pin_edge_sync

`default_nettype wire

// File: tb/pin_partner.sv
// Behavioural model of the external clock pin and the capture pins.
`timescale 1ns/10ps
`default_nettype none

module pin_partner (
  input  wire logic       clk_in,
  output logic            ext_pin_out,
  output logic      [3:0] cap_pin_out
);

  // Both pins rest low between pulses.
  initial begin
    ext_pin_out = 1'b0;
    cap_pin_out = 4'h0;
  end

  // Drives a high pulse on the external clock pin, rising edge active.
  task automatic ext_pulse(input int w);
    int n;
    n = (w < 2) ? 2 : w;
    @(posedge clk_in);
    ext_pin_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    ext_pin_out <= 1'b0;
  endtask : ext_pulse

  // Drives a high pulse on one capture pin, never narrower than two clocks.
  task automatic cap_pulse(input int idx, input int w);
    int n;
    n = (w < 2) ? 2 : w;
    @(posedge clk_in);
    cap_pin_out[idx] <= 1'b1;
    repeat (n) @(posedge clk_in);
    cap_pin_out[idx] <= 1'b0;
  endtask : cap_pulse

endmodule : pin_partner
`default_nettype wire

// File: tb/tb_periodic_timer_pulse_capture.sv
// Self-checking bench for the pulse output and capture input modes.
`include "periodic_timer_map.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_periodic_timer_pulse_capture;
  import periodic_timer_pkg::*;

  logic        clk_in;
  logic        rst_in;
  bus_req_t    bus_req;
  logic [7:0]  rdata_out;
  logic        ext_pin;
  logic [3:0]  cap_pin;
  logic        tout;
  logic        tint;
  logic        trun;
  logic [7:0]  d;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          int_cnt = 0;
  int          base;
  int          w;
  int          i;
  int          exp_int[4] = '{1, 1, 2, 0};

  periodic_timer_pulse_capture u_dut (
    .clk_in                 (clk_in),
    .rst_in                 (rst_in),
    .bus_in                 (bus_req),
    .rdata_out              (rdata_out),
    .timer_ext_clock_pin_in (ext_pin),
    .timer_capture_pin_in   (cap_pin),
    .timer_output_out       (tout),
    .timer_int_out          (tint),
    .timer_run_out          (trun)
  );

  pin_partner u_pins (
    .clk_in      (clk_in),
    .ext_pin_out (ext_pin),
    .cap_pin_out (cap_pin)
  );

  // Timer clock at 25 MHz.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Counts interrupt pulses and cuts a hang short.
  always @(posedge clk_in) begin
    cycles++;
    if (tint === 1'b1) int_cnt++;
    if (cycles == 6000) begin
      bad_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe with address and data.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_req <= '0;
  endtask : wr

  // One-cycle read strobe; data is taken in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_req <= '0;
    #1 v = rdata_out;
  endtask : rd

  // Exact comparison of a ten-bit result.
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Comparison of a timing-dependent result against a window.
  task automatic chk_rng(input string n, input int lo, input int hi,
                         input logic [9:0] g);
    total_checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      bad_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask : chk_rng

  // Waits n edges, then lets the registered outputs settle before a look.
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : idle

  // Restarts the counter by a run bit fall and rise.
  task automatic restart();
    wr(`PT_ADDR_CTRL0, 8'h00);
    wr(`PT_ADDR_CTRL0, 8'h01);
  endtask : restart

  // Counts the cycles that the run bit stays high.
  task automatic run_len(output int n);
    n = 0;
    while (trun === 1'b1 && n < 2000) begin
      @(posedge clk_in);
      #1 n++;
    end
  endtask : run_len

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    bus_req = '0;
    rst_in  = 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    idle(3);
    chk("run_reset", 10'h000, {9'h000, trun});
    chk("out_reset", 10'h001, {9'h000, tout});
    rd(`PT_ADDR_COMPARE_A_VALUE_LO, d);
    chk("compare_a_value_reset", 10'h000, {2'b00, d});
    rd(4'hF, d);
    chk("unmapped", 10'h000, {2'b00, d});
    wr(`PT_ADDR_COMPARE_A_VALUE_HI, 8'hFF);
    rd(`PT_ADDR_COMPARE_A_VALUE_HI, d);
    chk("compare_a_value_hi", 10'h003, {2'b00, d});
    wr(`PT_ADDR_COMPARE_A_VALUE_HI, 8'h00);
    // Single pulses by firmware; a short period must not matter.
    wr(`PT_ADDR_PERIOD_COMPARE_VALUE_LO, 8'h02);
    wr(`PT_ADDR_CTRL1, 8'hB8);
    idle(1);
    chk("out_idle", 10'h000, {9'h000, tout});
    for (i = 0; i < 2; i++) begin
      wr(`PT_ADDR_COMPARE_A_VALUE_LO, 8'(5 + 4 * i));
      base = int_cnt;
      wr(`PT_ADDR_CTRL0, 8'h01);
      #1 chk("out_lead", 10'h001, {9'h000, tout});
      run_len(w);
      chk_rng("pulse_len", 5 + 4 * i, 7 + 4 * i, 10'(w));
      idle(2);
      chk("pulse_int", 10'h001, 10'(int_cnt - base));
      chk("out_trail", 10'h000, {9'h000, tout});
    end
    // Pulse started by the external clock pin.
    wr(`PT_ADDR_COMPARE_A_VALUE_LO, 8'h08);
    base = int_cnt;
    fork
      u_pins.ext_pulse(3);
    join_none
    w = 0;
    while (trun !== 1'b1 && w < 12) begin
      @(posedge clk_in);
      #1 w++;
    end
    chk("ext_run", 10'h001, {9'h000, trun});
    chk("ext_out", 10'h001, {9'h000, tout});
    run_len(w);
    idle(2);
    chk("ext_int", 10'h001, 10'(int_cnt - base));
    // Inverted level, pulse ended by firmware before the match.
    wr(`PT_ADDR_CTRL1, 8'hBC);
    wr(`PT_ADDR_COMPARE_A_VALUE_LO, 8'hFF);
    wr(`PT_ADDR_COMPARE_A_VALUE_HI, 8'h03);
    base = int_cnt;
    wr(`PT_ADDR_CTRL0, 8'h01);
    idle(4);
    chk("inv_active", 10'h000, {9'h000, tout});
    wr(`PT_ADDR_CTRL0, 8'h00);
    idle(2);
    chk("fw_run", 10'h000, {9'h000, trun});
    chk("fw_out", 10'h001, {9'h000, tout});
    chk("fw_int", 10'h000, 10'(int_cnt - base));
    ////////////////////////////////////////////////////////////////////////////
    // Capture mode, full counter range, pin 0: rising edges, then each edge select.
    wr(`PT_ADDR_PERIOD_COMPARE_VALUE_LO, 8'h00);
    wr(`PT_ADDR_CTRL1, 8'h40);
    restart();
    idle(20);
    u_pins.cap_pulse(0, 4);
    idle(4);
    rd(`PT_ADDR_COMPARE_A_VALUE_LO, d);
    chk_rng("cap_value", 19, 26, {2'b00, d});
    for (i = 0; i < 4; i++) begin
      wr(`PT_ADDR_CTRL1, 8'(8'h40 + 16 * i));
      restart();
      base = int_cnt;
      u_pins.cap_pulse(0, 6);
      idle(6);
      chk("edge_int", 10'(exp_int[i]), 10'(int_cnt - base));
    end
    rd(`PT_ADDR_COMPARE_B_VALUE_LO, d);
    chk("compare_b_value_unused", 10'h000, {2'b00, d});
    // Source selection: pin 2, then the external clock pin.
    wr(`PT_ADDR_CTRL1, 8'h40);
    wr(`PT_ADDR_INSRC, 8'h80);
    base = int_cnt;
    u_pins.cap_pulse(0, 4);
    idle(6);
    chk("src_other", 10'h000, 10'(int_cnt - base));
    u_pins.cap_pulse(2, 4);
    idle(6);
    chk("src_pin2", 10'h001, 10'(int_cnt - base));
    wr(`PT_ADDR_CTRL1, 8'h42);
    base = int_cnt;
    u_pins.ext_pulse(4);
    idle(6);
    chk("src_ext", 10'h001, 10'(int_cnt - base));
    // Both edges; each nonzero clear condition sets what the fall captures.
    wr(`PT_ADDR_INSRC, 8'h00);
    wr(`PT_ADDR_CTRL1, 8'h60);
    for (i = 1; i < 4; i++) begin
      wr(`PT_ADDR_CTRL2, 8'(i));
      restart();
      idle(10);
      u_pins.cap_pulse(0, 20);
      idle(6);
      rd(`PT_ADDR_COMPARE_B_VALUE_LO, d);
      if (i == 2)
        chk_rng("compare_b_value_fall", 28, 36, {2'b00, d});
      else
        chk_rng("compare_b_value_rise", 17, 23, {2'b00, d});
    end
    // Period match with no captures; the polarity bit must not move the pin.
    wr(`PT_ADDR_CTRL2, 8'h00);
    wr(`PT_ADDR_CTRL1, 8'h74);
    wr(`PT_ADDR_PERIOD_COMPARE_VALUE_LO, 8'h0A);
    restart();
    base = int_cnt;
    idle(44);
    chk_rng("period_int", 3, 4, 10'(int_cnt - base));
    chk("cap_out", 10'h001, {9'h000, tout});
    rd(`PT_ADDR_CNT_LO, d);
    chk_rng("period_cnt", 0, 10, {2'b00, d});
    end_sim();
  end

endmodule : tb_periodic_timer_pulse_capture
`default_nettype wire
